// ---- shared/pfs_pkg.sv ----
package pfs_pkg;
   // ----------------------------------------
   // limits
   // ----------------------------------------
   localparam int         NUM_FLAGS = 10;
   localparam int         SUB_MAX   = 6;
   localparam int         NEST_MAX  = 11;
   localparam logic [15:0] ID_MAX   = 16'h01ff;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_INSTR  = 8'h00;
   localparam logic [7:0] OFS_OPND_A = 8'h04;
   localparam logic [7:0] OFS_OPND_B = 8'h08;
   localparam logic [7:0] OFS_CFG    = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_RESULT = 8'h14;
   localparam logic [7:0] OFS_OUTSEL = 8'h18;
   localparam int         BIT_ERR31  = 16;
   localparam int         BIT_NESTER = 17;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;
   // ----------------------------------------
   // command and option codes
   // ----------------------------------------
   localparam logic [7:0] CMD_END     = 8'h00;
   localparam logic [7:0] CMD_SUB1_HI = 8'h09;
   localparam logic [7:0] CMD_FLAG_HI = 8'h0a;
   localparam logic [7:0] CMD_FLAG_LO = 8'h14;
   localparam logic [7:0] CMD_THEN    = 8'h1e;
   localparam logic [7:0] CMD_EXIT_T  = 8'h1f;
   localparam logic [7:0] CMD_EXIT_F  = 8'h20;
   localparam logic [7:0] CMD_P1_SET  = 8'h29;
   localparam logic [7:0] CMD_P1_CLR  = 8'h33;
   localparam logic [7:0] CMD_P1_TOG  = 8'h3d;
   localparam logic [7:0] CMD_P1_PLS  = 8'h47;
   localparam logic [7:0] CMD_SUB_LO  = 8'h4f;
   localparam logic [7:0] CMD_SUB_HI  = 8'h63;
   localparam logic [7:0] SUB_PORT    = 8'h62;
   localparam logic [7:0] OPT_FS1B    = 8'h01;
   localparam logic [7:0] OPT_FS2     = 8'h02;
   localparam logic [7:0] OPT_INPUT   = 8'h03;
   localparam logic [2:0] CMP_EQ      = 3'h1;
   localparam logic [2:0] CMP_NE      = 3'h2;
   localparam logic [2:0] CMP_GE      = 3'h3;
   localparam logic [2:0] CMP_LT      = 3'h4;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {AREA_FS1, AREA_FS2, AREA_INPUT} pfs_area_e;
   typedef enum logic [1:0] {FR_LOOP, FR_COND1, FR_COND2} pfs_frame_e;
   typedef enum logic [3:0] {OP_TABLE_START, OP_TABLE_END, OP_SET_AREA, OP_DO, OP_IF_XY,
      OP_CASE_BEGIN, OP_IF_CASE, OP_LOOP, OP_END, OP_ELSE, OP_RETURN, OP_INDEX,
      OP_IDLE} pfs_op_e;
   typedef enum logic [3:0] {ACT_NONE, ACT_CALL, ACT_RETURN, ACT_END_TABLE, ACT_GOTO_ELSE,
      ACT_GOTO_END, ACT_EXIT_LOOP, ACT_REPEAT, ACT_WAIT, ACT_RESUME_LOOP, ACT_SKIP_TABLE,
      ACT_GOTO_END_CASE} pfs_act_e;
   typedef struct packed {
      logic [6:0] rsv;
      logic [2:0] cmp;
      logic [8:0] ipos;
      logic       has_else;
      logic [7:0] arg;
      pfs_op_e    op;
   } pfs_instr_s;
   typedef struct packed {
      pfs_frame_e  typ;
      logic [15:0] count;
      logic [15:0] iter;
      logic [15:0] delay;
      logic [8:0]  pos;
   } pfs_frame_s;
   typedef struct packed {
      logic p_s1, p_s2, p_prev;
      logic [31:0] tick_cnt;
      logic aw_got, w_got, bvalid, rvalid;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata, instr, opnd_a, opnd_b, case_val;
      logic sub98, port1, pulse, case_hit;
      logic [NUM_FLAGS-1:0] flags;
      pfs_area_e area;
      logic [8:0] array_id, flag0_pos;
      logic [15:0] dest_loc;
      logic [2:0] sub_sp, int_depth;
      logic [SUB_MAX-1:0][8:0] ret;
      logic int_pend, int_busy, dly, err31, nest_err;
      logic [3:0] sp;
      pfs_frame_s [NEST_MAX-1:0] fr;
      logic [15:0] wait_cnt, res_val;
      logic [1:0] table_id, dly_table;
      pfs_act_e res_act;
      logic [8:0] res_pos;
   } pfs_state_s;
   localparam pfs_state_s ST_RESET = '0;
endpackage

// ---- hw/pfs_program_flow_sequencer.sv ----
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module pfs_program_flow_sequencer
   import pfs_pkg::*;
#(
   parameter int INTERVAL_CYCLES = 200_000_000
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 awvalid,
   output      logic                 awready,
   input  wire logic [7:0]           awaddr,
   input  wire logic                 wvalid,
   output      logic                 wready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   output      logic                 bvalid,
   input  wire logic                 bready,
   output      logic [1:0]           bresp,
   input  wire logic                 arvalid,
   output      logic                 arready,
   input  wire logic [7:0]           araddr,
   output      logic                 rvalid,
   input  wire logic                 rready,
   output      logic [31:0]          rdata,
   output      logic [1:0]           rresp,
   input  wire logic                 interrupt_control_port,
   output      logic                 port1_out,
   output      logic [NUM_FLAGS-1:0] flags_out
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic cmp_true(input logic [2:0] code, input logic [31:0] a,
                                     input logic [31:0] b);
      unique case (code)
         CMP_EQ:  cmp_true = (a == b);
         CMP_NE:  cmp_true = (a != b);
         CMP_GE:  cmp_true = ($signed(a) >= $signed(b));
         CMP_LT:  cmp_true = ($signed(a) < $signed(b));
         default: cmp_true = 1'b0;
      endcase
   endfunction

   function automatic logic [4:0] nest_of(input pfs_frame_s [NEST_MAX-1:0] fr,
                                          input logic [3:0] sp);
      nest_of = '0;
      for (int i = 0; i < NEST_MAX; i++) begin
         if (4'(i) < sp) begin
            nest_of = nest_of + ((fr[i].typ == FR_COND2) ? 5'd2 : 5'd1);
         end
      end
   endfunction

   function automatic logic [4:0] inner_loop(input pfs_frame_s [NEST_MAX-1:0] fr,
                                             input logic [3:0] sp);
      inner_loop = '0;
      for (int i = 0; i < NEST_MAX; i++) begin
         if (4'(i) < sp && fr[i].typ == FR_LOOP) begin
            inner_loop = {1'b1, 4'(i)};
         end
      end
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            o[8*i +: 8] = d[8*i +: 8];
         end
      end
      wmerge = o;
   endfunction

   // ----------------------------------------
   // state and decode
   // ----------------------------------------
   pfs_state_s s;
   pfs_state_s n;
   logic       tick;
   logic       wr_go;
   logic       ex;
   pfs_instr_s ins;
   logic [7:0] cmd;
   logic       c_en;
   logic       c_true;
   logic       run;
   logic       is_call;
   logic [4:0] nest;
   logic [4:0] in_lp;
   logic [8:0] ret_top;

   assign tick    = (s.tick_cnt == 32'(INTERVAL_CYCLES - 1));
   assign wr_go   = s.aw_got && s.w_got && !s.bvalid;
   assign ex      = wr_go && (s.awaddr == OFS_INSTR);
   assign ins     = pfs_instr_s'(wmerge(s.instr, s.wdata, s.wstrb));
   assign cmd     = ins.arg;
   assign c_en    = (ins.op == OP_DO) || (ins.op == OP_IF_XY) || (ins.op == OP_IF_CASE);
   assign c_true  = (ins.op == OP_IF_XY) ? cmp_true(ins.cmp, s.opnd_a, s.opnd_b) :
                    (ins.op == OP_IF_CASE) ? ($signed(s.case_val) < $signed(s.opnd_a)) :
                    1'b1;
   assign run     = c_en && (cmd != CMD_THEN) && ((cmd == CMD_EXIT_F) ? !c_true : c_true);
   assign is_call = (cmd != CMD_END && cmd <= CMD_SUB1_HI) ||
                    (cmd >= CMD_SUB_LO && cmd <= CMD_SUB_HI);
   assign nest    = nest_of(s.fr, s.sp);
   assign in_lp   = inner_loop(s.fr, s.sp);
   assign ret_top = s.ret[s.sub_sp - 3'd1];

   assign awready   = !s.aw_got;
   assign wready    = !s.w_got;
   assign bvalid    = s.bvalid;
   assign bresp     = s.bresp;
   assign arready   = !s.rvalid;
   assign rvalid    = s.rvalid;
   assign rdata     = s.rdata;
   assign rresp     = s.rresp;
   assign port1_out = s.port1;
   assign flags_out = s.flags;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = s;
      n.p_s1   = interrupt_control_port;
      n.p_s2   = s.p_s1;
      n.p_prev = s.p_s2;
      n.tick_cnt = tick ? '0 : s.tick_cnt + 32'd1;
      if (tick) begin
         if (s.pulse) begin
            n.port1 = 1'b0;
            n.pulse = 1'b0;
         end
         if (s.dly && s.wait_cnt != '0) begin
            n.wait_cnt = s.wait_cnt - 16'd1;
         end
      end
      if (awvalid && !s.aw_got) begin
         n.aw_got = 1'b1;
         n.awaddr = awaddr;
      end
      if (wvalid && !s.w_got) begin
         n.w_got = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      if (s.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = RESP_OKAY;
         case (s.awaddr)
            OFS_INSTR:  n.instr  = ins;
            OFS_OPND_A: n.opnd_a = wmerge(s.opnd_a, s.wdata, s.wstrb);
            OFS_OPND_B: n.opnd_b = wmerge(s.opnd_b, s.wdata, s.wstrb);
            OFS_CFG:    if (s.wstrb[0]) n.sub98 = s.wdata[0];
            OFS_STATUS: begin
               if (s.wstrb[2] && s.wdata[BIT_ERR31]) n.err31 = 1'b0;
               if (s.wstrb[2] && s.wdata[BIT_NESTER]) n.nest_err = 1'b0;
            end
            OFS_RESULT, OFS_OUTSEL: ;
            default:    n.bresp = RESP_SLV;
         endcase
      end
      if (ex) begin
         n.res_act = ACT_NONE;
         n.res_pos = ins.ipos;
         unique case (ins.op)
            OP_TABLE_START: begin
               if (s.dly) begin
                  if (ins.arg[1:0] == s.dly_table && s.wait_cnt == '0) begin
                     n.res_act = ACT_RESUME_LOOP;
                     n.res_pos = s.fr[s.sp - 4'd1].pos + 9'd1;
                     n.table_id = s.dly_table;
                  end else begin
                     n.res_act = ACT_SKIP_TABLE;
                  end
               end else begin
                  n.table_id = ins.arg[1:0];
                  n.area     = AREA_FS1;
                  n.flags[0] = 1'b0;
                  n.sp       = '0;
               end
            end
            OP_TABLE_END: n.table_id = '0;
            OP_SET_AREA: begin
               if (cmd <= OPT_FS2) begin
                  n.area = (cmd == OPT_FS2) ? AREA_FS2 : AREA_FS1;
                  if (s.opnd_a[15:0] == '0) begin
                     n.array_id = (s.flag0_pos > ins.ipos) ? s.flag0_pos : ins.ipos;
                  end else if (s.opnd_a[15:0] <= ID_MAX) begin
                     n.array_id = s.opnd_a[8:0];
                  end
               end else if (cmd == OPT_INPUT) begin
                  n.area     = AREA_INPUT;
                  n.dest_loc = s.opnd_a[15:0];
               end
            end
            OP_CASE_BEGIN: begin
               n.case_val = s.opnd_a;
               n.case_hit = 1'b0;
            end
            OP_LOOP: begin
               if (nest + 5'd1 > 5'(NEST_MAX)) begin
                  n.nest_err = 1'b1;
               end else begin
                  n.fr[s.sp] = '{FR_LOOP, s.opnd_a[31:16], 16'h0000, s.opnd_a[15:0],
                                 ins.ipos};
                  n.sp = s.sp + 4'd1;
               end
            end
            OP_END: begin
               if (s.sp != '0) begin
                  if (s.fr[s.sp - 4'd1].typ != FR_LOOP) begin
                     n.sp = s.sp - 4'd1;
                  end else if (s.fr[s.sp - 4'd1].count != '0 &&
                               s.fr[s.sp - 4'd1].iter + 16'd1 >= s.fr[s.sp - 4'd1].count) begin
                     n.sp  = s.sp - 4'd1;
                     n.dly = 1'b0;
                  end else begin
                     n.fr[s.sp - 4'd1].iter = s.fr[s.sp - 4'd1].iter + 16'd1;
                     n.res_pos = s.fr[s.sp - 4'd1].pos + 9'd1;
                     if (s.fr[s.sp - 4'd1].delay == '0) begin
                        n.res_act = ACT_REPEAT;
                     end else begin
                        n.res_act   = ACT_WAIT;
                        n.dly       = 1'b1;
                        n.wait_cnt  = s.fr[s.sp - 4'd1].delay;
                        n.dly_table = s.table_id;
                     end
                  end
               end
            end
            OP_ELSE: begin
               if (s.sp != '0 && s.fr[s.sp - 4'd1].typ == FR_COND2) begin
                  n.sp      = s.sp - 4'd1;
                  n.res_act = ACT_GOTO_END;
               end
            end
            OP_RETURN: begin
               if (s.sub_sp != '0) begin
                  n.sub_sp  = s.sub_sp - 3'd1;
                  n.res_act = ACT_RETURN;
                  n.res_pos = ret_top + 9'd1;
                  if (s.int_busy && s.int_depth == s.sub_sp - 3'd1) n.int_busy = 1'b0;
               end
            end
            OP_INDEX: begin
               n.res_val = s.opnd_a[15:0];
               if (ins.arg[0] && in_lp[4]) begin
                  n.res_val = s.opnd_a[15:0] + s.fr[in_lp[3:0]].iter;
               end
            end
            OP_DO, OP_IF_XY, OP_IF_CASE, OP_IDLE: ;
            default: ;
         endcase
         if (c_en && cmd == CMD_THEN) begin
            if (!c_true && !ins.has_else) begin
               n.res_act = ACT_GOTO_END;
            end else if (nest + (ins.has_else ? 5'd2 : 5'd1) > 5'(NEST_MAX)) begin
               n.nest_err = 1'b1;
            end else begin
               n.fr[s.sp] = '{ins.has_else ? FR_COND2 : FR_COND1, 16'h0000, 16'h0000,
                              16'h0000, ins.ipos};
               n.sp = s.sp + 4'd1;
               if (!c_true) n.res_act = ACT_GOTO_ELSE;
            end
         end
         if (run) begin
            if (cmd == CMD_END) begin
               n.sub_sp   = '0;
               n.int_busy = 1'b0;
               n.sp       = '0;
               n.dly      = 1'b0;
               n.res_act  = ACT_END_TABLE;
            end else if (is_call) begin
               if (s.sub_sp == 3'(SUB_MAX)) begin
                  n.err31 = 1'b1;
               end else begin
                  n.ret[s.sub_sp] = ins.ipos;
                  n.sub_sp  = s.sub_sp + 3'd1;
                  n.res_act = ACT_CALL;
                  n.res_pos = {1'b0, cmd};
               end
            end else if (cmd >= CMD_FLAG_HI && cmd < CMD_FLAG_LO) begin
               n.flags[4'(cmd - CMD_FLAG_HI)] = 1'b1;
               if (cmd == CMD_FLAG_HI) n.flag0_pos = ins.ipos;
            end else if (cmd >= CMD_FLAG_LO && cmd < CMD_THEN) begin
               n.flags[4'(cmd - CMD_FLAG_LO)] = 1'b0;
            end else if (cmd == CMD_EXIT_T || cmd == CMD_EXIT_F) begin
               if (in_lp[4]) begin
                  n.sp      = in_lp[3:0];
                  n.dly     = 1'b0;
                  n.res_act = ACT_EXIT_LOOP;
               end
            end else if (cmd == CMD_P1_SET) begin
               n.port1 = 1'b1;
            end else if (cmd == CMD_P1_CLR) begin
               n.port1 = 1'b0;
            end else if (cmd == CMD_P1_TOG) begin
               n.port1 = !s.port1;
            end else if (cmd == CMD_P1_PLS) begin
               n.port1 = 1'b1;
               n.pulse = 1'b1;
            end
         end
         if (ins.op == OP_IF_CASE) begin
            if (n.res_act == ACT_CALL || n.res_act == ACT_END_TABLE) n.case_hit = 1'b1;
            else if (s.case_hit || (c_true && cmd != CMD_THEN))
               n.res_act = ACT_GOTO_END_CASE;
            else if (c_true) n.case_hit = 1'b1;
         end
         if (s.int_pend && s.sub98 && !n.int_busy && n.res_act == ACT_NONE &&
             n.sub_sp < 3'(SUB_MAX)) begin
            n.ret[n.sub_sp] = ins.ipos;
            n.int_depth = n.sub_sp;
            n.sub_sp    = n.sub_sp + 3'd1;
            n.int_busy  = 1'b1;
            n.int_pend  = 1'b0;
            n.res_act   = ACT_CALL;
            n.res_pos   = {1'b0, SUB_PORT};
         end
      end
      if (s.p_s2 && !s.p_prev && s.sub98 && !n.int_busy) begin
         n.int_pend = 1'b1;
      end
      if (s.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      if (arvalid && !s.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         n.rdata  = '0;
         case (araddr)
            OFS_INSTR:  n.rdata = s.instr;
            OFS_OPND_A: n.rdata = s.opnd_a;
            OFS_OPND_B: n.rdata = s.opnd_b;
            OFS_CFG:    n.rdata = {31'h0000_0000, s.sub98};
            OFS_STATUS: n.rdata = {6'h00, s.table_id, nest, s.dly, s.nest_err, s.err31,
                                   s.int_pend, s.int_busy, s.sub_sp, s.port1, s.flags};
            OFS_RESULT: n.rdata = {s.res_val, 3'h0, s.res_pos, s.res_act};
            OFS_OUTSEL: n.rdata = {s.dest_loc, 3'h0, s.array_id, 2'h0, s.area};
            default:    n.rresp = RESP_SLV;
         endcase
      end
      if (!aresetn) begin
         n = ST_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      s <= n;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_AREA_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
      ex && ins.op == OP_TABLE_START && !s.dly |=> s.area == AREA_FS1 && !s.flags[0])
      else $error("area or output flag not reset at table start");
   AST_SUB_DEPTH: assert property (@(posedge aclk) disable iff (!aresetn)
      s.sub_sp <= 3'(SUB_MAX)) else $error("subroutine depth above six");
   AST_ERR31: assert property (@(posedge aclk) disable iff (!aresetn)
      ex && run && is_call && s.sub_sp == 3'(SUB_MAX) |=> s.err31 && $stable(s.sub_sp))
      else $error("seventh call not refused");
   AST_NEST_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
      nest <= 5'(NEST_MAX)) else $error("nesting above eleven");
   AST_INT_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
      s.int_busy && !s.int_pend ##1 s.int_busy |-> !s.int_pend)
      else $error("port edge taken while interrupt runs");
   AST_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn)
      ex && run && cmd == CMD_P1_TOG |=> s.port1 != $past(s.port1))
      else $error("port 1 did not toggle");
   AST_FLAG0: assert property (@(posedge aclk) disable iff (!aresetn)
      ex && run && cmd == CMD_FLAG_HI |=> s.flags[0] && s.flag0_pos == $past(ins.ipos))
      else $error("output flag not set");
   AST_END_SUB: assert property (@(posedge aclk) disable iff (!aresetn)
      ex && run && cmd == CMD_END |=> s.sub_sp == '0 && s.res_act == ACT_END_TABLE)
      else $error("end command did not abandon subroutines");
   AST_RETURN: assert property (@(posedge aclk) disable iff (!aresetn)
      ex && ins.op == OP_RETURN && s.sub_sp != '0 |=>
      s.res_act == ACT_RETURN && s.res_pos == $past(ret_top) + 9'd1)
      else $error("return position wrong");
endmodule

// ---- sim/pfs_port_driver.sv ----
`timescale 1ns/1ps
// drives control port 2 with a held high level per request
module pfs_port_driver (
   input  wire logic aclk,
   input  wire logic req,
   output      logic port
);
   logic [2:0] hold = 3'h0;
   assign port = (hold != 3'h0);
   always @(posedge aclk) begin
      if (req) begin
         hold <= 3'h5;
      end else if (hold != 3'h0) begin
         hold <= hold - 3'h1;
      end
   end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench import pfs_pkg::*;;
   logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req;
   logic                 awready, wready, bvalid, arready, rvalid, port, port1_out;
   logic [7:0]           awaddr, araddr;
   logic [31:0]          wdata, rdata, rd;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp, br, rr;
   logic [NUM_FLAGS-1:0] flags_out;
   logic                 p;
   int                   n_mismatch, n_checks, cyc;
   pfs_program_flow_sequencer #(.INTERVAL_CYCLES(8)) pfs_program_flow_sequencer_i (.aclk,
      .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .interrupt_control_port(port), .port1_out, .flags_out);
   pfs_port_driver pfs_port_driver_i (.aclk, .req, .port);
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= a;
      wdata   <= d;
      bready  <= 1'b1;
      do begin
         #1;
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         br = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      logic ta, tr;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do begin
         #1;
         ta = arvalid && arready;
         tr = rvalid;
         rd = rdata;
         rr = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
      rready <= 1'b0;
   endtask
   function automatic logic [31:0] ins(input logic [3:0] op, input logic [7:0] arg,
                                       input logic [8:0] pos, input logic [2:0] c);
      return {7'h00, c, pos, 1'b0, arg, op};
   endfunction
   task automatic ckres(input logic [3:0] act, input logic [8:0] pos);
      rdr(OFS_RESULT);
      chk("result", 32'({pos, act}), 32'(rd[12:0]));
   endtask
   task automatic pulse();
      @(posedge aclk) req <= 1'b1;
      @(posedge aclk) req <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, req, awaddr, araddr, wdata} <= '0;
      wstrb <= 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(OFS_STATUS); chk("status", 32'h0000_0000, rd);
      rdr(OFS_OUTSEL); chk("outsel", 32'h0000_0000, rd);
      rdr(8'h1c); chk("rresp", 32'(RESP_SLV), 32'(rr));
      wr(8'h1c, 32'h0000_0001); chk("bresp", 32'(RESP_SLV), 32'(br));
      $display("test reset done");
      wr(OFS_CFG, 32'h0000_0001);
      pulse();
      wr(OFS_INSTR, ins(4'hc, 8'h00, 9'h000, 3'h0));
      ckres(4'h1, 9'h062);
      pulse();
      rdr(OFS_STATUS); chk("busy", 32'h0000_0001, 32'(rd[15:14]));
      wr(OFS_INSTR, ins(4'ha, 8'h00, 9'h000, 3'h0));
      ckres(4'h2, 9'h001);
      $display("test interrupt done");
      wr(OFS_INSTR, ins(4'h0, 8'h01, 9'h001, 3'h0));
      for (int k = 1; k <= 6; k++) begin
         wr(OFS_INSTR, ins(4'h3, 8'(k), 9'(10 + k), 3'h0));
         ckres(4'h1, 9'(k));
      end
      wr(OFS_INSTR, ins(4'h3, 8'h07, 9'h011, 3'h0));
      rdr(OFS_STATUS); chk("depth", 32'h0000_0026, 32'(rd[16:11]));
      for (int k = 6; k >= 1; k--) begin
         wr(OFS_INSTR, ins(4'ha, 8'h00, 9'h000, 3'h0));
         ckres(4'h2, 9'(11 + k));
      end
      $display("test calls done");
      for (int k = 0; k < 10; k++) begin
         wr(OFS_INSTR, ins(4'h3, 8'(10 + k), 9'h020, 3'h0));
         chk("flags", 32'(10'(~(10'h3ff << (k + 1)))), 32'(flags_out));
      end
      for (int k = 0; k < 10; k++) begin
         wr(OFS_INSTR, ins(4'h3, 8'(20 + k), 9'h021, 3'h0));
         chk("flags", 32'(10'(10'h3ff << (k + 1))), 32'(flags_out));
      end
      wr(OFS_INSTR, ins(4'h3, 8'd41, 9'h022, 3'h0));
      chk("port1", 32'h0000_0001, 32'(port1_out));
      wr(OFS_INSTR, ins(4'h3, 8'd51, 9'h023, 3'h0));
      chk("port1", 32'h0000_0000, 32'(port1_out));
      wr(OFS_OPND_A, 32'h0000_0003);
      wr(OFS_OPND_B, 32'h0000_0005);
      p = 1'b0;
      for (int c = 1; c <= 4; c++) begin
         wr(OFS_INSTR, ins(4'h4, 8'd61, 9'h024, 3'(c)));
         p = p ^ (c == 2 || c == 4);
         chk("compare", 32'(p), 32'(port1_out));
      end
      $display("test commands done");
      wr(OFS_OPND_A, 32'h0000_0007);
      wr(OFS_INSTR, ins(4'h2, OPT_FS2, 9'h005, 3'h0));
      rdr(OFS_OUTSEL); chk("outsel", 32'h0000_0071, 32'(rd[12:0]));
      wr(OFS_OPND_A, 32'h0000_0020);
      wr(OFS_INSTR, ins(4'h2, OPT_INPUT, 9'h006, 3'h0));
      rdr(OFS_OUTSEL); chk("outsel", 32'h0020_0072, rd);
      wr(OFS_INSTR, ins(4'h0, 8'h01, 9'h001, 3'h0));
      rdr(OFS_OUTSEL); chk("area", 32'h0000_0000, 32'(rd[1:0]));
      wr(OFS_OPND_A, 32'h0000_0000);
      wr(OFS_INSTR, ins(4'h2, OPT_FS1B, 9'h008, 3'h0));
      rdr(OFS_OUTSEL); chk("array id", 32'h0000_0200, 32'(rd[12:0]));
      $display("test areas done");
      wr(OFS_OPND_A, 32'h0002_0000);
      wr(OFS_INSTR, ins(4'h7, 8'h00, 9'h030, 3'h0));
      for (int k = 0; k < 2; k++) begin
         wr(OFS_OPND_A, 32'h0000_0040);
         wr(OFS_INSTR, ins(4'hb, 8'h01, 9'h031, 3'h0));
         rdr(OFS_RESULT); chk("index", 32'(16'h0040 + k), 32'(rd[31:16]));
         wr(OFS_INSTR, ins(4'h8, 8'h00, 9'h032, 3'h0));
         ckres((k == 0) ? 4'h7 : 4'h0, (k == 0) ? 9'h031 : 9'h032);
      end
      wr(OFS_OPND_A, 32'h0000_0000);
      wr(OFS_INSTR, ins(4'h7, 8'h00, 9'h040, 3'h0));
      wr(OFS_INSTR, ins(4'h4, CMD_THEN, 9'h041, CMP_EQ));
      ckres(4'h5, 9'h041);
      wr(OFS_INSTR, ins(4'h3, CMD_EXIT_T, 9'h042, 3'h0));
      ckres(4'h6, 9'h042);
      rdr(OFS_STATUS); chk("nest", 32'h0000_0000, 32'(rd[23:19]));
      wr(OFS_INSTR, ins(4'h3, 8'd5, 9'h050, 3'h0));
      wr(OFS_INSTR, ins(4'h3, CMD_END, 9'h051, 3'h0));
      ckres(4'h3, 9'h051);
      rdr(OFS_STATUS); chk("depth", 32'h0000_0000, 32'(rd[13:11]));
      wr(OFS_OPND_A, 32'h0000_0002);
      wr(OFS_INSTR, ins(4'h5, 8'h00, 9'h060, 3'h0));
      for (int k = 0; k < 2; k++) begin
         wr(OFS_OPND_A, k ? 32'h0000_0009 : 32'h0000_0001);
         wr(OFS_INSTR, ins(4'h6, CMD_P1_SET, 9'(97 + k), 3'h0));
         ckres(k ? 4'hb : 4'h0, 9'(97 + k));
      end
      chk("port1", 32'h0000_0001, 32'(port1_out));
      wr(OFS_OPND_A, 32'h0002_0002);
      wr(OFS_INSTR, ins(4'h7, 8'h00, 9'h070, 3'h0));
      wr(OFS_INSTR, ins(4'h8, 8'h00, 9'h071, 3'h0));
      ckres(4'h8, 9'h071);
      wr(OFS_INSTR, ins(4'h3, CMD_FLAG_HI, 9'h072, 3'h0));
      wr(OFS_INSTR, ins(4'h0, 8'h02, 9'h001, 3'h0));
      ckres(4'ha, 9'h001);
      repeat (20) @(posedge aclk);
      wr(OFS_INSTR, ins(4'h0, 8'h01, 9'h001, 3'h0));
      ckres(4'h9, 9'h071);
      chk("flag0", 32'h0000_0001, 32'(flags_out[0]));
      wr(OFS_INSTR, ins(4'h8, 8'h00, 9'h071, 3'h0));
      ckres(4'h0, 9'h071);
      $display("test flow done");
      complete_run();
   end
endmodule
